// ===== src/mvic_ctrl.sv
// three-level vectored interrupt controller, top module
// source bus order (bit: source)
//  0 ext_irq_zero | 1 ext_irq_one
//  2 ext_irq_two 3 timer0_low_event 4 ext_irq_four 5 usb_host_port_a bus
//    6 usb_host_port_b bus 7 remote receive
//  8 ext_irq_three 9 ext_irq_five 10 base timer
//  11 timer0_high_event 12 ext_irq_six 13..15 usb_host_port_a conn/disc/resume
//  16 timer1_low_event 17 timer1_high_event 18 ext_irq_seven
//    19 audio_iface start 20 single_master_i2c_unit 21..23 usb_host_port_b
//  24 sync_serial_first 25 full_duplex_uart receive done
//  26 async_sync_serial 27 sync_serial_crc 28 uart empty 29 uart done
//    30 audio_iface end
//  31 adc 32 timer_six_event 33 timer_seven_event 34..37 usb ack/nak/err/stall
//  38 port 0 39 pwm_channel_a 40 pwm_channel_b 41 timer_four_event
//    42 timer_five_event 43 usb_host_frame_start
`timescale 1ns/1ps
module mvic_ctrl
    import mvic_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [MVIC_NUM_SRC-1:0] src_flag,
    input wire logic [MVIC_NUM_SRC-1:0] src_enable,
    input wire logic [MVIC_NUM_VEC-1:0] vec_level_sel,
    input wire logic irq_ack,
    input wire logic irq_return,
    output logic irq_req,
    output logic [MVIC_IDX_W-1:0] irq_vec_idx,
    output logic [MVIC_ADDR_W-1:0] irq_vector,
    output mvic_level_t irq_level,
    output mvic_level_t serve_level
);

    logic [MVIC_NUM_VEC-1:0] vec_pend;
    logic [2:0] ins_q;
    logic [2:0] ins_d;
    mvic_level_t cur_d;
    logic take;
    logic win_valid;
    logic [MVIC_IDX_W-1:0] win_idx;
    mvic_level_t win_lvl;
    logic req_q;
    logic [MVIC_IDX_W-1:0] idx_q;
    logic [MVIC_ADDR_W-1:0] addr_q;
    mvic_level_t lvl_q;
    mvic_level_t serve_q;

    // vector pending is the or of its enabled member flags
    always_comb
    begin
        for (int v = 0; v < MVIC_NUM_VEC; v++)
            vec_pend[v] = |(src_flag & src_enable & MVIC_SRC_MASK[v]);
    end

    // core takes the presented vector only while it is offered
    assign take = irq_ack && req_q;

    // nesting mask: return drops the top bit, acceptance sets its level
    always_comb
    begin
        ins_d = ins_q;
        if (irq_return)
        begin
            unique case (mvic_top_of(ins_q))
                MVIC_LVL_TOP: ins_d[MVIC_INS_TOP] = 1'b0;
                MVIC_LVL_HIGH: ins_d[MVIC_INS_HIGH] = 1'b0;
                MVIC_LVL_LOW: ins_d[MVIC_INS_LOW] = 1'b0;
                MVIC_LVL_NONE: ins_d = ins_q;
            endcase
        end
        if (take)
        begin
            unique case (lvl_q)
                MVIC_LVL_TOP: ins_d[MVIC_INS_TOP] = 1'b1;
                MVIC_LVL_HIGH: ins_d[MVIC_INS_HIGH] = 1'b1;
                MVIC_LVL_LOW: ins_d[MVIC_INS_LOW] = 1'b1;
                MVIC_LVL_NONE: ins_d[MVIC_INS_LOW] = ins_d[MVIC_INS_LOW];
            endcase
        end
        cur_d = mvic_top_of(ins_d);
    end

    // arbitration against the level that holds after this edge
    mvic_arbiter u_arb (
        .pend(vec_pend),
        .lvl_sel(vec_level_sel),
        .cur_lvl(cur_d),
        .win_valid(win_valid),
        .win_idx(win_idx),
        .win_lvl(win_lvl)
    );

    // in-service state
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ins_q <= MVIC_INS_RESET;
            serve_q <= MVIC_LVL_NONE;
        end
        else
        begin
            ins_q <= ins_d;
            serve_q <= cur_d;
        end
    end

    // offered vector, refreshed each cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            req_q <= 1'b0;
            idx_q <= MVIC_IDX_RESET;
            addr_q <= MVIC_ADDR_RESET;
            lvl_q <= MVIC_LVL_NONE;
        end
        else
        begin
            req_q <= win_valid;
            idx_q <= win_idx;
            addr_q <= MVIC_VEC_ADDR[win_idx];
            lvl_q <= win_lvl;
        end
    end

    assign irq_req = req_q;
    assign irq_vec_idx = idx_q;
    assign irq_vector = addr_q;
    assign irq_level = lvl_q;
    assign serve_level = serve_q;

    // independent check: some pending vector would beat the chosen one
    logic beats_w;
    always_comb
    begin
        mvic_level_t lv;
        lv = MVIC_LVL_NONE;
        beats_w = 1'b0;
        for (int v = 0; v < MVIC_NUM_VEC; v++)
        begin
            lv = mvic_vec_level(v, vec_level_sel[v]);
            if (vec_pend[v] && lv > cur_d && (lv > win_lvl ||
                (lv == win_lvl && MVIC_IDX_W'(v) < win_idx)))
                beats_w = 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // offered level is strictly above the one in service
    above_serve_a: assert property (irq_req |-> irq_level > serve_level)
        else $error("offered level not above service level");

    // acceptance raises service level to the offered one
    ack_raise_a: assert property (irq_req && irq_ack && !irq_return
        |=> serve_level == $past(irq_level))
        else $error("service level not raised on acceptance");

    // return with nothing accepted lowers the level
    ret_drop_a: assert property (irq_return && !irq_ack && serve_level != MVIC_LVL_NONE
        |=> serve_level < $past(serve_level))
        else $error("service level not restored on return");

    // pin vectors only at top or low
    pin_level_a: assert property (irq_req && irq_vec_idx < MVIC_FIRST_SHARED
        |-> irq_level inside {MVIC_LVL_TOP, MVIC_LVL_LOW})
        else $error("pin vector at wrong level");

    // shared vectors only at high or low
    shared_level_a: assert property (irq_req && irq_vec_idx >= MVIC_FIRST_SHARED
        |-> irq_level inside {MVIC_LVL_HIGH, MVIC_LVL_LOW})
        else $error("shared vector at wrong level");

    // no pending vector outranks the winner
    winner_best_a: assert property (irq_req |-> !$past(beats_w))
        else $error("a better vector was passed over");

    // offered vector had an enabled member raised, indexed by the pick of that cycle
    member_pend_a: assert property (irq_req |-> $past(vec_pend[win_idx]))
        else $error("vector offered without a pending member");

    // address matches the vector index
    addr_match_a: assert property (irq_req |-> irq_vector == MVIC_VEC_ADDR[irq_vec_idx])
        else $error("vector address does not match index");

    // all three levels busy means nothing can be offered
    full_nest_a: assert property (ins_q == 3'h7 |-> !irq_req)
        else $error("request offered with all levels busy");

    cov_accept_c: cover property (irq_req && irq_ack);
    cov_nest_c: cover property (serve_level == MVIC_LVL_LOW ##[1:50]
        serve_level == MVIC_LVL_TOP);
    cov_return_c: cover property (serve_level == MVIC_LVL_HIGH && irq_return);
    cov_tie_c: cover property (win_valid && $countones(vec_pend) > 1);

endmodule : mvic_ctrl

// ===== src/mvic_pkg.sv
// shared constants and types for the vectored interrupt controller
package mvic_pkg;

    // source and vector counts
    localparam int MVIC_NUM_SRC = 44;
    localparam int MVIC_NUM_VEC = 10;
    localparam int MVIC_IDX_W = 4;
    localparam int MVIC_ADDR_W = 20;

    // three service levels plus idle, ordered by code value
    typedef enum logic [1:0] {
        MVIC_LVL_NONE = 2'b00,
        MVIC_LVL_LOW = 2'b01,
        MVIC_LVL_HIGH = 2'b10,
        MVIC_LVL_TOP = 2'b11
    } mvic_level_t;

    // in-service mask bit positions, one per level
    localparam int MVIC_INS_LOW = 0;
    localparam int MVIC_INS_HIGH = 1;
    localparam int MVIC_INS_TOP = 2;
    localparam logic [2:0] MVIC_INS_RESET = 3'h0;

    // vectors below this index choose top or low, the rest high or low
    localparam logic [MVIC_IDX_W-1:0] MVIC_FIRST_SHARED = 4'h2;
    localparam logic [MVIC_IDX_W-1:0] MVIC_IDX_RESET = 4'h0;
    localparam logic [MVIC_ADDR_W-1:0] MVIC_ADDR_RESET = 20'h00000;

    // vector entry addresses, lowest address first
    localparam logic [MVIC_ADDR_W-1:0] MVIC_VEC_ADDR [MVIC_NUM_VEC] = '{
        20'h00003, 20'h0000b, 20'h00013, 20'h0001b, 20'h00023,
        20'h0002b, 20'h00033, 20'h0003b, 20'h00043, 20'h0004b
    };

    // member sources of each vector, as bit masks over the source bus
    localparam logic [MVIC_NUM_SRC-1:0] MVIC_SRC_MASK [MVIC_NUM_VEC] = '{
        44'h000_0000_0001, 44'h000_0000_0002, 44'h000_0000_00fc,
        44'h000_0000_0700, 44'h000_0000_f800, 44'h000_00ff_0000,
        44'h000_0300_0000, 44'h000_7c00_0000, 44'h03f_8000_0000,
        44'hfc0_0000_0000
    };

    // level of a vector from its one select bit
    function automatic mvic_level_t mvic_vec_level(input int idx, input logic sel);
        if (idx < int'(MVIC_FIRST_SHARED))
            return sel ? MVIC_LVL_TOP : MVIC_LVL_LOW;
        return sel ? MVIC_LVL_HIGH : MVIC_LVL_LOW;
    endfunction : mvic_vec_level

    // highest level still marked in service
    function automatic mvic_level_t mvic_top_of(input logic [2:0] ins);
        if (ins[MVIC_INS_TOP])
            return MVIC_LVL_TOP;
        if (ins[MVIC_INS_HIGH])
            return MVIC_LVL_HIGH;
        if (ins[MVIC_INS_LOW])
            return MVIC_LVL_LOW;
        return MVIC_LVL_NONE;
    endfunction : mvic_top_of

endpackage : mvic_pkg

// ===== src/mvic_arbiter.sv
// combinational winner pick among pending vectors
`timescale 1ns/1ps
module mvic_arbiter
    import mvic_pkg::*;
(
    input wire logic [MVIC_NUM_VEC-1:0] pend,
    input wire logic [MVIC_NUM_VEC-1:0] lvl_sel,
    input wire mvic_level_t cur_lvl,
    output logic win_valid,
    output logic [MVIC_IDX_W-1:0] win_idx,
    output mvic_level_t win_lvl
);

    // strictly greater keeps the lowest index on a tie
    always_comb
    begin
        mvic_level_t lv;
        lv = MVIC_LVL_NONE;
        win_valid = 1'b0;
        win_idx = MVIC_IDX_RESET;
        win_lvl = MVIC_LVL_NONE;
        for (int v = 0; v < MVIC_NUM_VEC; v++)
        begin
            lv = mvic_vec_level(v, lvl_sel[v]);
            if (pend[v] && lv > cur_lvl && lv > win_lvl)
            begin
                win_valid = 1'b1;
                win_idx = MVIC_IDX_W'(v);
                win_lvl = lv;
            end
        end
    end

endmodule : mvic_arbiter

// ===== bench/mvic_core_model.sv
// cpu core stand-in that accepts offered vectors after a set wait
`timescale 1ns/1ps
module mvic_core_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic irq_req,
    input wire logic ack_en,
    input wire logic [3:0] ack_wait,
    output logic irq_ack
);
    logic [3:0] cnt_q;

    // one-cycle accept pulse once an offer has stood ack_wait cycles
    always_ff @(negedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_ack <= 1'b0;
            cnt_q <= 4'h0;
        end
        else if (irq_ack || !ack_en || !irq_req)
        begin
            irq_ack <= 1'b0;
            cnt_q <= 4'h0;
        end
        else if (cnt_q >= ack_wait)
            irq_ack <= 1'b1;
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule : mvic_core_model

// ===== bench/mvic_ctrl_tb.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module mvic_ctrl_tb
    import mvic_pkg::*;
;
    logic clk, rstn, irq_ack, irq_return, irq_req, ack_en;
    logic [43:0] src_flag, src_enable;
    logic [9:0] vec_level_sel;
    logic [3:0] irq_vec_idx, ack_wait;
    logic [19:0] irq_vector;
    mvic_level_t irq_level, serve_level;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int last_src [10] = '{0, 1, 7, 10, 15, 23, 25, 30, 37, 43};

    mvic_ctrl i_dut (.clk(clk), .rstn(rstn), .src_flag(src_flag), .src_enable(src_enable),
        .vec_level_sel(vec_level_sel), .irq_ack(irq_ack), .irq_return(irq_return),
        .irq_req(irq_req), .irq_vec_idx(irq_vec_idx), .irq_vector(irq_vector),
        .irq_level(irq_level), .serve_level(serve_level));
    mvic_core_model i_core (.clk(clk), .rstn(rstn), .irq_req(irq_req), .ack_en(ack_en),
        .ack_wait(ack_wait), .irq_ack(irq_ack));

    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic chk_val(input string nm, input logic [19:0] exp, input logic [19:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask : chk_val

    task automatic chk_lvl(input string nm, input mvic_level_t exp, input mvic_level_t got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask : chk_lvl

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // poll the service level under a bound, then judge it
    task automatic wait_serve(input mvic_level_t exp);
        for (int i = 0; i < 12 && serve_level !== exp; i++)
            tick(1);
        chk_lvl("serve_level", exp, serve_level);
    endtask : wait_serve

    task automatic ret();
        irq_return = 1'b1;
        tick(1);
        irq_return = 1'b0;
    endtask : ret

    // every source alone reaches its own vector, and only when enabled
    task automatic t_map();
        int v;
        vec_level_sel = 10'h3ff;
        for (int s = 0; s < 44; s++)
        begin
            v = 0;
            while (last_src[v] < s)
                v++;
            src_flag = 44'h0;
            src_flag[s] = 1'b1;
            tick(2);
            chk_val("req", 20'h1, 20'(irq_req));
            chk_val("idx", 20'(v), 20'(irq_vec_idx));
            chk_val("vector", 20'h3 + 20'(8 * v), irq_vector);
            chk_lvl("level", v < 2 ? MVIC_LVL_TOP : MVIC_LVL_HIGH, irq_level);
            src_enable[s] = 1'b0;
            tick(2);
            chk_val("masked", 20'h0, 20'(irq_req));
            src_enable[s] = 1'b1;
        end
        src_flag = 44'h0;
    endtask : t_map

    // two vectors at once: level first, then lowest address
    task automatic t_arb();
        int ca [5] = '{3, 3, 1, 0, 8};
        int cb [5] = '{5, 5, 9, 9, 2};
        int cw [5] = '{3, 5, 9, 0, 2};
        logic [9:0] cs [5] = '{10'h000, 10'h020, 10'h200, 10'h201, 10'h000};
        for (int k = 0; k < 5; k++)
        begin
            vec_level_sel = cs[k];
            src_flag = 44'h0;
            src_flag[last_src[ca[k]]] = 1'b1;
            src_flag[last_src[cb[k]]] = 1'b1;
            tick(2);
            chk_val("winner", 20'(cw[k]), 20'(irq_vec_idx));
        end
        src_flag = 44'h0;
    endtask : t_arb

    // nesting low, high, top, then unwinding by returns
    task automatic t_nest();
        vec_level_sel = 10'h000;
        ack_wait = 4'h4;
        ack_en = 1'b1;
        src_flag[7] = 1'b1;
        wait_serve(MVIC_LVL_LOW);
        src_flag[10] = 1'b1;
        tick(3);
        chk_val("equal refused", 20'h0, 20'(irq_req));
        ack_wait = 4'h0;
        vec_level_sel[4] = 1'b1;
        src_flag[15] = 1'b1;
        wait_serve(MVIC_LVL_HIGH);
        vec_level_sel[0] = 1'b1;
        src_flag[0] = 1'b1;
        wait_serve(MVIC_LVL_TOP);
        ack_en = 1'b0;
        src_flag = 44'h0;
        src_flag[7] = 1'b1;
        ret();
        wait_serve(MVIC_LVL_HIGH);
        ret();
        wait_serve(MVIC_LVL_LOW);
        chk_val("low held", 20'h0, 20'(irq_req));
        ret();
        wait_serve(MVIC_LVL_NONE);
        tick(2);
        chk_val("reoffer", 20'h1, 20'(irq_req));
        chk_lvl("reoffer level", MVIC_LVL_LOW, irq_level);
        src_flag = 44'h0;
        ret();
        wait_serve(MVIC_LVL_NONE);
    endtask : t_nest

    // reset, then the scenarios in turn
    initial
    begin
        rstn = 1'b0;
        src_flag = 44'h0;
        src_enable = {44{1'b1}};
        vec_level_sel = 10'h000;
        irq_return = 1'b0;
        ack_en = 1'b0;
        ack_wait = 4'h0;
        repeat (8) @(posedge clk);
        tick(1);
        chk_val("reset req", 20'h0, 20'(irq_req));
        chk_lvl("reset serve", MVIC_LVL_NONE, serve_level);
        rstn = 1'b1;
        tick(1);
        t_map();
        t_arb();
        t_nest();
        conclude();
    end
endmodule : mvic_ctrl_tb
